// ===== design/bca_top.sv
// word FIFO and the cipher accelerator core with its register port
// assumes one clock, synchronous active-high reset, master never waits
//
// The plain strobed port and the address map were chosen for this implementation.
`default_nettype none

// small synchronous FIFO, valid/ready on both sides
module bca_fifo #(parameter int W = 32, parameter int D = 8) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic clr_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(D):0] count_o
);
  logic [W-1:0] mem_q [D];
  logic [$clog2(D)-1:0] wp_q, rp_q;
  logic push, pop;
  assign in_ready_o = (count_o != D[$clog2(D):0]);
  assign out_valid_o = (count_o != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem_q[rp_q];
  // storage write
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
  // pointers and fill count
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || clr_i) begin
      wp_q <= '0;
      rp_q <= '0;
      count_o <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      count_o <= count_o + {{$clog2(D){1'b0}}, push} - {{$clog2(D){1'b0}}, pop};
    end
  end
endmodule

module bca_top import bca_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic dma_in_req_o,
  output logic dma_out_req_o,
  output logic busy_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_RUN, ST_STORE} bca_st_t;
  bca_req_t req;
  bca_ctrl_t ctrl_q;
  bca_st_t st_q;
  logic [31:0] key_q [8];
  logic [31:0] iv_q [4];
  logic [127:0] blk_q, hold_q;
  logic [7:0] rnd_q, nrnd;
  logic [1:0] wcnt_q;
  logic [1:0] nw_m1;
  logic bad_cfg;
  logic in_vld, in_rdy, out_vld, out_rdy, core_pop, core_push;
  logic [31:0] in_word, out_word, push_word;
  logic [3:0] in_cnt, out_cnt;
  logic [127:0] chain_in, chain_out;
  logic rdec, room;
  logic [2:0] kidx;

  // swap in both directions: half-word, byte or bit order
  function automatic logic [31:0] swap_w(input logic [31:0] w, input bca_swap_t s);
    logic [31:0] r;
    r = w;
    case (s)
      SW_HALF: r = {w[15:0], w[31:16]};
      SW_BYTE: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
      SW_BIT: for (int i = 0; i < 32; i++) r[i] = w[31-i];
      default: r = w;
    endcase
    return r;
  endfunction

  // one invertible keyed round; des works on the low 64 bits only
  function automatic logic [127:0] round_f(input logic [127:0] x, input logic [31:0] k,
                                           input logic dec, input logic des);
    logic [127:0] kk, r;
    kk = {4{k}};
    r = x;
    if (des) begin
      // decrypt undoes the key mix and the rotate-left-by-five of encrypt
      if (dec) r[63:0] = ((x[63:0] ^ kk[63:0]) >> 5) | ((x[63:0] ^ kk[63:0]) << 59);
      else r[63:0] = {x[58:0], x[63:59]} ^ kk[63:0];
      r[127:64] = 64'h0;
    end else begin
      if (dec) r = ((x ^ kk) >> 5) | ((x ^ kk) << 123);
      else r = {x[122:0], x[127:123]} ^ kk;
    end
    return r;
  endfunction

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // control and key words held for the engines
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_q <= bca_ctrl_t'(CTRL_RST);
      for (int i = 0; i < 8; i++) key_q[i] <= 32'h0;
    end else begin
      // flush lasts one cycle whatever the next access is; a control write still wins
      if (ctrl_q.flush) ctrl_q.flush <= 1'b0;
      if (req.wr && req.addr == OFS_CTRL) ctrl_q <= bca_ctrl_t'(req.wdata[12:0]);
      // keys are write-only: no read path leaks them
      if (req.wr && (req.addr[5:4] == OFS_KEY[5:4] || req.addr[5:4] == 2'b10))
        key_q[3'(req.addr[5:2] - 4'h4)] <= req.wdata;
    end
  end

  // illegal selections: counter mode on DES/TDES, reserved codes
  assign bad_cfg = (ctrl_q.alg == ALG_RSV) || (ctrl_q.mode == MD_RSV)
                 || (ctrl_q.alg != ALG_AES && ctrl_q.mode == MD_CTR)
                 || (ctrl_q.ksz == 2'b11);

  // round count and block width from algorithm and key size
  always_comb begin
    nrnd = RND_DES;
    nw_m1 = 2'd1;
    case (ctrl_q.alg)
      ALG_TDES: nrnd = 8'(RND_DES * 3);
      ALG_AES: begin
        nw_m1 = 2'd3;
        case (ctrl_q.ksz)
          2'd1: nrnd = RND_AES192;
          2'd2: nrnd = RND_AES256;
          default: nrnd = RND_AES128;
        endcase
      end
      default: nrnd = RND_DES;
    endcase
  end

  // input FIFO: pushed by data-input writes through the swap unit
  bca_fifo #(.W(FIFO_W), .D(FIFO_D)) u_in_fifo (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clr_i(ctrl_q.flush),
    .in_valid_i(req.wr && req.addr == OFS_DIN),
    .in_ready_o(in_rdy), .in_data_i(swap_w(req.wdata, ctrl_q.swap)),
    .out_valid_o(in_vld), .out_ready_i(core_pop), .out_data_o(in_word), .count_o(in_cnt)
  );

  // output FIFO: filled by the core, popped by data-output reads
  bca_fifo #(.W(FIFO_W), .D(FIFO_D)) u_out_fifo (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clr_i(ctrl_q.flush),
    .in_valid_i(core_push), .in_ready_o(out_rdy), .in_data_i(push_word),
    .out_valid_o(out_vld), .out_ready_i(req.rd && req.addr == OFS_DOUT),
    .out_data_o(out_word), .count_o(out_cnt)
  );

  assign core_pop = (st_q == ST_LOAD) && in_vld;
  assign core_push = (st_q == ST_STORE);
  assign push_word = chain_out[32*wcnt_q +: 32];
  // chaining: CBC xors the vector before encrypt or after decrypt; CTR encrypts the counter
  assign chain_in = (ctrl_q.mode == MD_CTR) ? {iv_q[3], iv_q[2], iv_q[1], iv_q[0]} :
                    (ctrl_q.mode == MD_CBC && !ctrl_q.dec) ?
                    hold_q ^ {iv_q[3], iv_q[2], iv_q[1], iv_q[0]} : hold_q;
  assign chain_out = (ctrl_q.mode == MD_CTR) ? blk_q ^ hold_q :
                     (ctrl_q.mode == MD_CBC && ctrl_q.dec) ?
                     blk_q ^ {iv_q[3], iv_q[2], iv_q[1], iv_q[0]} : blk_q;

  // round direction and key pick: decrypt outside CTR walks the key words in reverse order
  assign rdec = ctrl_q.dec && ctrl_q.mode != MD_CTR;
  assign kidx = rdec ? 3'(nrnd - 8'h1 - rnd_q) : 3'(rnd_q);
  // output room for a whole block, so no unread word is ever overwritten
  assign room = (4'(FIFO_D) - out_cnt) > {2'b00, nw_m1};

  // block sequencer: load, run rounds, store when the output has room
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || ctrl_q.flush) begin
      st_q <= ST_IDLE;
      wcnt_q <= 2'd0;
      rnd_q <= 8'h0;
      hold_q <= '0;
      blk_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: if (ctrl_q.en && !bad_cfg) st_q <= ST_LOAD;
        ST_LOAD: if (in_vld) begin
          hold_q[32*wcnt_q +: 32] <= in_word;
          wcnt_q <= wcnt_q + 2'd1;
          if (wcnt_q == nw_m1) begin
            wcnt_q <= 2'd0;
            rnd_q <= 8'h0;
            st_q <= ST_RUN;
          end
        end
        // each round runs once; the finished block then waits here for output room
        ST_RUN: begin
          if (rnd_q != nrnd) begin
            blk_q <= round_f((rnd_q == 8'h0) ? chain_in : blk_q, key_q[kidx], rdec,
                             ctrl_q.alg != ALG_AES);
            rnd_q <= rnd_q + 8'h1;
          end else if (room) begin
            st_q <= ST_STORE;
          end
        end
        ST_STORE: begin
          wcnt_q <= wcnt_q + 2'd1;
          if (wcnt_q == nw_m1) begin
            wcnt_q <= 2'd0;
            st_q <= ctrl_q.en ? ST_LOAD : ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // vector words: software writes, CBC and CTR advance them per block
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 4; i++) iv_q[i] <= 32'h0;
    end else if (req.wr && req.addr[5:4] == OFS_IV[5:4]) begin
      iv_q[req.addr[3:2]] <= req.wdata;
    end else if (st_q == ST_STORE && wcnt_q == nw_m1) begin
      if (ctrl_q.mode == MD_CTR) {iv_q[1], iv_q[0]} <= {iv_q[1], iv_q[0]} + 64'h1;
      if (ctrl_q.mode == MD_CBC)
        {iv_q[3], iv_q[2], iv_q[1], iv_q[0]} <= ctrl_q.dec ? hold_q : blk_q;
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h0;
    end else if (req.rd) begin
      case (req.addr)
        OFS_CTRL: rdata_o <= {19'h0, ctrl_q};
        OFS_STAT: rdata_o <= {16'h0, out_cnt, in_cnt, 3'h0, bad_cfg, out_vld, in_rdy, st_q};
        OFS_DOUT: rdata_o <= out_vld ? swap_w(out_word, ctrl_q.swap) : 32'h0;
        default: rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  // dma requests and busy flag, registered
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dma_in_req_o <= 1'b0;
      dma_out_req_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      dma_in_req_o <= ctrl_q.dma_in && ctrl_q.en && in_cnt < 4'(FIFO_D - 1);
      dma_out_req_o <= ctrl_q.dma_out && out_cnt > 4'h1;
      busy_o <= (st_q != ST_IDLE);
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // a refused selection never starts the rounds
  no_ctr_des_a: assert property ((ctrl_q.alg != ALG_AES && ctrl_q.mode == MD_CTR)
    |-> st_q != ST_RUN || $past(st_q) == ST_RUN) else $error("ctr started on des");
  bad_idle_a: assert property ((st_q == ST_IDLE && bad_cfg) |=> st_q == ST_IDLE)
    else $error("bad config left idle");
  // fifo bookkeeping on the register side
  in_push_a: assert property ((req.wr && req.addr == OFS_DIN && in_rdy && !ctrl_q.flush
    && !core_pop) |=> in_cnt == $past(in_cnt) + 4'h1) else $error("din lost");
  out_pop_a: assert property ((req.rd && req.addr == OFS_DOUT && out_vld && !core_push
    && !ctrl_q.flush) |=> out_cnt == $past(out_cnt) - 4'h1) else $error("dout no pop");
  rd_idle_a: assert property (!req.rd |=> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  no_overrun_a: assert property (core_push |-> out_rdy) else $error("output overrun");
  fifo_depth_a: assert property (in_cnt <= 4'(FIFO_D) && out_cnt <= 4'(FIFO_D))
    else $error("fifo count beyond depth");
  flush_clr_a: assert property (ctrl_q.flush |=> in_cnt == 4'h0 && out_cnt == 4'h0)
    else $error("flush left words behind");
  // dma request levels follow the fill counts
  dma_in_a: assert property ((ctrl_q.dma_in && ctrl_q.en && in_cnt < 4'h2)
    |=> dma_in_req_o) else $error("no input dma request");
  dma_out_on_a: assert property ((ctrl_q.dma_out && out_cnt > 4'h1) |=> dma_out_req_o)
    else $error("no output dma request");
  dma_out_off_a: assert property (!ctrl_q.dma_out |=> !dma_out_req_o)
    else $error("spurious output dma");
  // block shape for DES and AES, round count for AES
  aes_rounds_a: assert property ((st_q == ST_STORE && ctrl_q.alg == ALG_AES)
    |-> rnd_q >= 8'd10) else $error("aes stored early");
  store_len_a: assert property ($rose(core_push) && ctrl_q.alg == ALG_DES
    |-> ##1 core_push ##1 !core_push) else $error("des block not two words");
  aes_len_a: assert property ($rose(core_push) && ctrl_q.alg == ALG_AES
    |-> ##1 core_push ##1 core_push ##1 core_push ##1 !core_push)
    else $error("aes block not four words");
  ctr_step_a: assert property ((st_q == ST_STORE && wcnt_q == nw_m1 &&
    ctrl_q.mode == MD_CTR && !req.wr) |=> {iv_q[1], iv_q[0]} == $past({iv_q[1], iv_q[0]}) + 64'h1)
    else $error("counter not advanced");
  aes_blk_c: cover property (st_q == ST_STORE && ctrl_q.alg == ALG_AES && ctrl_q.mode == MD_CTR);
  tdes_blk_c: cover property (st_q == ST_STORE && ctrl_q.alg == ALG_TDES && ctrl_q.dec);
  stall_c: cover property (st_q == ST_RUN && rnd_q == nrnd && out_cnt > 4'h5);
  des_cbc_c: cover property (core_push && ctrl_q.alg == ALG_DES && ctrl_q.mode == MD_CBC);
  dma_both_c: cover property (dma_in_req_o && dma_out_req_o);
endmodule
`default_nettype wire

// ===== dv/bca_dma_model.sv
// dma partner: fills the input fifo and drains the output fifo on request
// assumes the bench hands it the register port while en_i is high
`default_nettype none
module bca_dma_model import bca_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic en_i,
  input wire logic [3:0] gap_i,
  input wire logic in_req_i,
  input wire logic out_req_i,
  input wire logic [31:0] rdata_i,
  output logic [5:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rx_q [8];
  int tx_n = 0;
  int rx_n = 0;
  // one transfer per look, then a pause so the request level can follow the count
  initial begin
    addr_o = 6'h00;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    forever begin
      @(posedge clk_sys_i);
      if (!en_i) begin
        tx_n = 0;
        rx_n = 0;
      end else if (in_req_i && tx_n < 8) begin
        addr_o <= OFS_DIN;
        wdata_o <= 32'h5a5a0000 + 32'(tx_n);
        wr_o <= 1'b1;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        addr_o <= ~addr_o; // released bus shows no stale value
        wdata_o <= ~wdata_o;
        tx_n++;
        repeat (gap_i + 1) @(posedge clk_sys_i);
      end else if (out_req_i && rx_n < 8) begin
        addr_o <= OFS_DOUT;
        rd_o <= 1'b1;
        @(posedge clk_sys_i);
        rd_o <= 1'b0;
        addr_o <= ~addr_o;
        @(negedge clk_sys_i);
        rx_q[rx_n] = rdata_i;
        rx_n++;
        repeat (gap_i + 1) @(posedge clk_sys_i);
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/bca_top_tb_top.sv
// bench: register port, round trips per algorithm, swap, stall, dma
// assumes bca_top and the dma partner model are compiled before it
`default_nettype none
module bca_top_tb_top import bca_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, sys_rst_i, t_wr, t_rd, p_wr, p_rd, dma_sel, in_req, out_req, busy;
  logic [5:0] t_addr, p_addr;
  logic [31:0] t_wdata, p_wdata, rdata, d;
  logic [31:0] pt [8];
  logic [31:0] ct [8];
  logic [31:0] bi [8];
  logic [31:0] bo [8];
  logic [3:0] gap;
  bca_ctrl_t c;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  bca_top bca_top_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .addr_i(dma_sel ? p_addr : t_addr), .wdata_i(dma_sel ? p_wdata : t_wdata),
    .wr_i(dma_sel ? p_wr : t_wr), .rd_i(dma_sel ? p_rd : t_rd), .rdata_o(rdata),
    .dma_in_req_o(in_req), .dma_out_req_o(out_req), .busy_o(busy));
  bca_dma_model bca_dma_model_i (.clk_sys_i(clk_sys_i), .en_i(dma_sel), .gap_i(gap),
    .in_req_i(in_req), .out_req_i(out_req), .rdata_i(rdata), .addr_o(p_addr),
    .wdata_o(p_wdata), .wr_o(p_wr), .rd_o(p_rd));
  // system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // hang guard, well above the expected run
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    t_addr <= a;
    t_wdata <= v;
    t_wr <= 1'b1;
    @(posedge clk_sys_i);
    t_wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    t_addr <= a;
    t_rd <= 1'b1;
    @(posedge clk_sys_i);
    t_rd <= 1'b0;
    @(negedge clk_sys_i);
    v = rdata;
    @(posedge clk_sys_i);
  endtask
  function automatic bca_ctrl_t mk(input bca_alg_t a, input bca_mode_t m,
                                   input logic [1:0] k, input bca_swap_t s);
    mk = '0;
    mk.en = 1'b1;
    mk.alg = a;
    mk.mode = m;
    mk.ksz = k;
    mk.swap = s;
  endfunction
  function automatic logic [31:0] swf(input logic [31:0] w, input bca_swap_t m);
    swf = w;
    if (m == SW_HALF) swf = {w[15:0], w[31:16]};
    if (m == SW_BYTE) swf = {w[7:0], w[15:8], w[23:16], w[31:24]};
    if (m == SW_BIT) for (int i = 0; i < 32; i++) swf[i] = w[31 - i];
  endfunction
  // poll the output fill level, then check it
  task automatic wait_out(input logic [3:0] f);
    for (int k = 0; k < 400 && d[15:12] != f; k++) rd(OFS_STAT, d);
    cmp(32'(d[15:12]), 32'(f));
  endtask
  // flush, reload the vector words, then configure
  task automatic setup();
    wr(OFS_CTRL, 32'h1000);
    for (int i = 0; i < 4; i++) wr(OFS_IV + 6'(4 * i), 32'h0f1e2d3c ^ 32'(i));
    wr(OFS_CTRL, 32'(c));
  endtask
  task automatic crypt();
    setup();
    for (int i = 0; i < 8; i++) wr(OFS_DIN, bi[i]);
    d = 32'h0;
    wait_out(4'h8);
    for (int i = 0; i < 8; i++) rd(OFS_DOUT, bo[i]);
  endtask
  // encrypt, text must change; decrypt, text must come back
  task automatic round(input bca_alg_t a, input bca_mode_t m, input logic [1:0] k,
                       input bca_swap_t s);
    c = mk(a, m, k, s);
    bi = pt;
    crypt();
    ct = bo;
    n = 0;
    for (int i = 0; i < 8; i++) n += int'(ct[i] != pt[i]);
    cmp(32'(n > 0), 32'h1);
    c.dec = 1'b1;
    bi = ct;
    crypt();
    for (int i = 0; i < 8; i++) cmp(bo[i], pt[i]);
  endtask
  initial begin
    sys_rst_i = 1'b1;
    {t_wr, t_rd, dma_sel, t_addr, t_wdata, gap} = '0;
    for (int i = 0; i < 8; i++) pt[i] = 32'h6bc1bee2 + 32'(i) * 32'h01010101;
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(OFS_CTRL, d);
    cmp(d, 32'h0);
    wr(OFS_STAT, 32'hffffffff);
    rd(OFS_STAT, d);
    cmp(32'(d[15:2]), 32'h1);
    rd(6'h02, d);
    cmp(d, 32'h0);
    rd(OFS_DOUT, d);
    cmp(d, 32'h0);
    for (int i = 0; i < 8; i++) wr(OFS_KEY + 6'(4 * i), 32'h2b7e1516 ^ (32'(i) << 4));
    // key words are write-only and read back as zero
    rd(OFS_KEY + 6'h1c, d);
    cmp(d, 32'h0);
    for (int i = 0; i < 9; i++) wr(OFS_DIN, pt[i % 8]);
    rd(OFS_STAT, d);
    cmp(32'(d[11:2]), 32'h200);
    wr(OFS_CTRL, 32'h1000);
    rd(OFS_STAT, d);
    cmp(32'(d[15:8]), 32'h0);
    for (int i = 0; i < 2; i++) begin
      c = i ? mk(ALG_AES, MD_ECB, 2'h3, SW_NONE) : mk(ALG_DES, MD_CTR, 2'h0, SW_NONE);
      setup();
      for (int j = 0; j < 4; j++) wr(OFS_DIN, pt[j]);
      repeat (100) @(posedge clk_sys_i);
      rd(OFS_STAT, d);
      cmp(32'({d[15:12], d[4]}), 32'h1);
    end
    round(ALG_DES, MD_ECB, 2'h0, SW_NONE);
    round(ALG_DES, MD_CBC, 2'h0, SW_HALF);
    round(ALG_TDES, MD_ECB, 2'h0, SW_NONE);
    round(ALG_TDES, MD_CBC, 2'h1, SW_BYTE);
    round(ALG_TDES, MD_ECB, 2'h2, SW_BIT);
    round(ALG_AES, MD_ECB, 2'h0, SW_NONE);
    round(ALG_AES, MD_CBC, 2'h1, SW_NONE);
    round(ALG_AES, MD_CTR, 2'h2, SW_BYTE);
    for (int m = 1; m < 4; m++) begin
      c = mk(ALG_DES, MD_ECB, 2'h0, SW_NONE);
      for (int i = 0; i < 8; i++) bi[i] = swf(pt[i], bca_swap_t'(m));
      crypt();
      ct = bo;
      c.swap = bca_swap_t'(m);
      bi = pt;
      crypt();
      for (int i = 0; i < 8; i++) cmp(bo[i], swf(ct[i], c.swap));
    end
    c = mk(ALG_AES, MD_ECB, 2'h0, SW_NONE);
    setup();
    for (int i = 0; i < 12; i++) wr(OFS_DIN, pt[i % 8]);
    repeat (200) @(posedge clk_sys_i);
    rd(OFS_STAT, d);
    cmp(32'({busy, d[15:12]}), 32'h18);
    for (int i = 0; i < 8; i++) rd(OFS_DOUT, d);
    wait_out(4'h4);
    for (int g = 0; g < 2; g++) begin
      c = mk(ALG_AES, MD_CBC, 2'h0, SW_NONE);
      for (int i = 0; i < 8; i++) bi[i] = 32'h5a5a0000 + 32'(i);
      crypt();
      ct = bo;
      c.dma_in = 1'b1;
      c.dma_out = 1'b1;
      gap <= 4'(3 * g);
      setup();
      @(negedge clk_sys_i);
      cmp(32'(in_req), 32'h1);
      @(posedge clk_sys_i);
      dma_sel <= 1'b1;
      // the core stays busy loading while enabled, so wait on the partner's counts
      for (int k = 0; k < 3000 && (bca_dma_model_i.tx_n != 8 || bca_dma_model_i.rx_n != 7);
           k++)
        @(posedge clk_sys_i);
      repeat (8) @(posedge clk_sys_i);
      n = bca_dma_model_i.rx_n;
      cmp(32'(n), 32'h7);
      dma_sel <= 1'b0;
      @(posedge clk_sys_i);
      for (int i = 0; i < 8; i++) begin
        if (i >= n) rd(OFS_DOUT, d);
        else d = bca_dma_model_i.rx_q[i];
        cmp(d, ct[i]);
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== shared/bca_pkg.sv
// package of constants and carriers for the block cipher accelerator
// assumes a single system clock and a plain strobe register port
`default_nettype none
package bca_pkg;
  localparam int FIFO_W = 32;
  localparam int FIFO_D = 8;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STAT = 6'h04;
  localparam logic [5:0] OFS_DIN = 6'h08;
  localparam logic [5:0] OFS_DOUT = 6'h0c;
  localparam logic [5:0] OFS_KEY = 6'h10; // eight key words up to 6'h2c
  localparam logic [5:0] OFS_IV = 6'h30; // four vector words up to 6'h3c
  localparam logic [12:0] CTRL_RST = 13'h0000;
  localparam logic [7:0] RND_DES = 8'h10;
  localparam logic [7:0] RND_AES128 = 8'h0a;
  localparam logic [7:0] RND_AES192 = 8'h0c;
  localparam logic [7:0] RND_AES256 = 8'h0e;
  typedef enum logic [1:0] {ALG_DES, ALG_TDES, ALG_AES, ALG_RSV} bca_alg_t;
  typedef enum logic [1:0] {MD_ECB, MD_CBC, MD_CTR, MD_RSV} bca_mode_t;
  typedef enum logic [1:0] {SW_NONE, SW_HALF, SW_BYTE, SW_BIT} bca_swap_t;
  // control word layout, lsb first: enable, decrypt, alg, mode, key size, swap, dma, flush
  typedef struct packed {
    logic flush;
    logic dma_out;
    logic dma_in;
    bca_swap_t swap;
    logic [1:0] ksz;
    bca_mode_t mode;
    bca_alg_t alg;
    logic dec;
    logic en;
  } bca_ctrl_t;
  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bca_req_t;
endpackage
`default_nettype wire
